// ==== rtl/adc_seq_pkg.sv ====
// Purpose: shared constants for the converter sequencer control block
// Assumes: APB slave, 32-bit data, one register per aligned word
// Notes: offsets and field positions are used by the top and its helpers
package adc_seq_pkg;
    // register byte offsets
    localparam logic [7:0] OFF_CTRL0 = 8'h00; // power, start, busy, channel
    localparam logic [7:0] OFF_CTRL1 = 8'h04; // divider, internal source
    localparam logic [7:0] OFF_TRIG = 8'h08; // trigger source, format, compare enables
    localparam logic [7:0] OFF_HLIM = 8'h0C; // high boundary, 12 bits
    localparam logic [7:0] OFF_LLIM = 8'h10; // low boundary, 12 bits
    localparam logic [7:0] OFF_RESULT = 8'h14; // aligned result, two bytes
    localparam logic [7:0] OFF_STATUS = 8'h18; // done and compare flags, write one clears
    // control0 fields
    localparam int CH_LSB = 0; // external channel select [3:0]
    localparam int START_BIT = 4; // software start bit
    localparam int PWR_BIT = 5; // power enable
    localparam int BUSY_BIT = 6; // busy flag, read only
    // control1 fields
    localparam int DIV_LSB = 0; // divider select [2:0]
    localparam int SRC_LSB = 4; // internal source select [6:4]
    // trigger control fields
    localparam int TSRC_BIT = 0; // 1 selects pwm trigger path
    localparam int ALIGN_BIT = 1; // 1 right aligned
    localparam int LCMP_BIT = 2; // low boundary compare enable
    localparam int HCMP_BIT = 3; // high boundary compare enable
    // status fields
    localparam int DONE_BIT = 0; // conversion end request
    localparam int CMP_BIT = 1; // boundary exceeded request
    // sequence lengths in converter clock periods
    localparam int SAMPLE_CYCLES = 4;
    localparam int CONVERT_CYCLES = 12;
    // mux codes
    localparam logic [2:0] SRC_AMP = 3'h1;
    localparam logic [2:0] SRC_GND_A = 3'h2;
    localparam logic [2:0] SRC_GND_B = 3'h3;
    localparam logic [3:0] CH_FLOAT_A = 4'hE;
    localparam logic [3:0] CH_FLOAT_B = 4'hF;
    // input select one-hot: 14 external lines, amp, ground
    localparam int NUM_EXT = 14;
    localparam int SEL_AMP = 14;
    localparam int SEL_GND = 15;
endpackage

// ==== rtl/conv_clk_div.sv ====
// Purpose: converter clock enable from the system clock
// Assumes: one pulse every 2**sel system cycles while running
// Notes: sel 0 gives an enable every cycle
`timescale 1ns/100ps
`default_nettype none
module conv_clk_div #(
    parameter int WIDTH = 7
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic run,
    input wire logic [2:0] sel,
    output logic tick
);
    logic [WIDTH-1:0] cnt_reg; // free count within a period
    logic [WIDTH-1:0] mask; // low bits that must all be ones
    assign mask = WIDTH'((8'h01 << sel) - 8'h01);
    // restart on idle so every conversion sees full periods
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_reg <= '0;
        end else if (!run) begin
            cnt_reg <= '0;
        end else begin
            cnt_reg <= cnt_reg + WIDTH'(1);
        end
    end
    assign tick = run && ((cnt_reg & mask) == mask);
endmodule
`default_nettype wire

// ==== rtl/input_mux_sel.sv ====
// Purpose: decode of the converter input selection
// Assumes: one-hot switch controls, all zero means floating input
// Notes: reserved channel codes connect nothing
`timescale 1ns/100ps
`default_nettype none
module input_mux_sel (
    input wire logic [2:0] src,
    input wire logic [3:0] ch,
    output logic [15:0] sel
);
    logic ext_mode; // external channel routing active
    logic ch_ok; // channel code names a real input
    assign ext_mode = !(src == adc_seq_pkg::SRC_AMP || src == adc_seq_pkg::SRC_GND_A
                        || src == adc_seq_pkg::SRC_GND_B);
    // codes 0..7, 9, 12, 13 exist; 8,10,11 reserved; 14,15 float
    assign ch_ok = (ch <= 4'h7) || (ch == 4'h9) || (ch == 4'hC) || (ch == 4'hD);
    always_comb begin
        sel = 16'h0000;
        if (ext_mode && ch_ok) begin
            sel[ch] = 1'b1;
        end
        if (src == adc_seq_pkg::SRC_AMP) begin
            sel[adc_seq_pkg::SEL_AMP] = 1'b1;
        end
        if (src == adc_seq_pkg::SRC_GND_A || src == adc_seq_pkg::SRC_GND_B) begin
            sel[adc_seq_pkg::SEL_GND] = 1'b1;
        end
    end
endmodule
`default_nettype wire

// ==== rtl/adc_sequencer_control.sv ====
// Purpose: apb control of a 12-bit converter: clock, power, mux, sequence, limits
// Assumes: analog core takes sample/convert strobes and returns a 12-bit code
// Notes: one clock domain; only the pwm trigger input is synchronised here
//
// Local design decisions: the APB slave port and the register addresses.
`timescale 1ns/100ps
`default_nettype none
module adc_sequencer_control #(
    parameter int DATA_BITS = 12
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic pwm_trigger,
    input wire logic [DATA_BITS-1:0] conv_data,
    input wire logic [13:0] pin_function_sel_reg,
    output logic conv_power_enable,
    output logic [15:0] input_switch,
    output logic sample_strobe,
    output logic convert_strobe,
    output logic [13:0] pin_digital_disable,
    output logic conv_done_irq,
    output logic compare_irq
);
    // sequencer states
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_SAMPLE = 3'b010,
        ST_CONVERT = 3'b100
    } seq_state_e;

    // software registers
    logic [6:0] conv_control_reg0; // channel, start, power
    logic [6:0] conv_control_reg1; // divider, internal source
    logic [3:0] conv_trigger_ctrl_reg; // trigger, align, compare enables
    logic [DATA_BITS-1:0] high_limit_reg; // high boundary word
    logic [DATA_BITS-1:0] low_limit_reg; // low boundary word
    logic [DATA_BITS-1:0] result_reg; // last raw result
    logic done_flag_reg; // conversion end request
    logic cmp_flag_reg; // boundary exceeded request
    logic conv_busy_flag; // conversion in progress
    seq_state_e state_reg, state_next;
    logic [3:0] phase_cnt_reg, phase_cnt_next; // converter periods left in phase, less one
    logic start_prev_reg; // start bit last cycle
    logic pwm_meta_reg, pwm_sync_reg, pwm_prev_reg; // trigger synchroniser
    logic [31:0] prdata_reg; // read data held after access
    logic pready_reg, pslverr_reg;
    logic power_reg; // power output flop
    logic [15:0] switch_reg; // mux output flops
    logic sample_reg, convert_reg; // strobe output flops
    logic [13:0] pin_dis_reg; // pin override flops

    // decoded fields
    logic [3:0] ext_channel_sel;
    logic [2:0] internal_source_sel;
    logic [2:0] conv_clock_div_sel;
    logic start_bit, trigger_source_sel, result_align_sel;
    logic low_limit_cmp_enable, high_limit_cmp_enable;
    assign ext_channel_sel = conv_control_reg0[adc_seq_pkg::CH_LSB +: 4];
    assign start_bit = conv_control_reg0[adc_seq_pkg::START_BIT];
    assign conv_power_enable = power_reg;
    assign conv_clock_div_sel = conv_control_reg1[adc_seq_pkg::DIV_LSB +: 3];
    assign internal_source_sel = conv_control_reg1[adc_seq_pkg::SRC_LSB +: 3];
    assign trigger_source_sel = conv_trigger_ctrl_reg[adc_seq_pkg::TSRC_BIT];
    assign result_align_sel = conv_trigger_ctrl_reg[adc_seq_pkg::ALIGN_BIT];
    assign low_limit_cmp_enable = conv_trigger_ctrl_reg[adc_seq_pkg::LCMP_BIT];
    assign high_limit_cmp_enable = conv_trigger_ctrl_reg[adc_seq_pkg::HCMP_BIT];

    // apb decode: no wait states, unmapped access gets an error
    logic access, wr_en, rd_en, addr_ok;
    assign access = psel && penable;
    assign addr_ok = (paddr <= adc_seq_pkg::OFF_STATUS) && (paddr[1:0] == 2'b00);
    assign wr_en = access && pwrite && addr_ok;
    // read data is latched in the setup cycle so it already stands at the access edge
    assign rd_en = psel && !penable && !pwrite && addr_ok;
    logic wr_ctrl0, wr_ctrl1, wr_trig, wr_hlim, wr_llim, wr_stat;
    assign wr_ctrl0 = wr_en && paddr == adc_seq_pkg::OFF_CTRL0;
    assign wr_ctrl1 = wr_en && paddr == adc_seq_pkg::OFF_CTRL1;
    assign wr_trig = wr_en && paddr == adc_seq_pkg::OFF_TRIG;
    assign wr_hlim = wr_en && paddr == adc_seq_pkg::OFF_HLIM;
    assign wr_llim = wr_en && paddr == adc_seq_pkg::OFF_LLIM;
    assign wr_stat = wr_en && paddr == adc_seq_pkg::OFF_STATUS;

    // aligned result: left keeps low nibble zero, right keeps top nibble zero
    logic [15:0] result_aligned;
    assign result_aligned = result_align_sel ? {4'h0, result_reg}
                                             : {result_reg, 4'h0};

    // read mux
    logic [31:0] rd_mux;
    always_comb begin
        rd_mux = 32'h00000000;
        case (paddr)
            adc_seq_pkg::OFF_CTRL0: rd_mux = {25'h0, conv_busy_flag, conv_control_reg0[5:0]};
            adc_seq_pkg::OFF_CTRL1: rd_mux = {25'h0, conv_control_reg1};
            adc_seq_pkg::OFF_TRIG: rd_mux = {28'h0, conv_trigger_ctrl_reg};
            adc_seq_pkg::OFF_HLIM: rd_mux = {20'h0, high_limit_reg};
            adc_seq_pkg::OFF_LLIM: rd_mux = {20'h0, low_limit_reg};
            adc_seq_pkg::OFF_RESULT: rd_mux = {16'h0, result_aligned};
            adc_seq_pkg::OFF_STATUS: rd_mux = {30'h0, cmp_flag_reg, done_flag_reg};
            default: rd_mux = 32'h00000000;
        endcase
    end

    // bus response flops
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_reg <= 32'h00000000;
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
        end else begin
            if (rd_en) begin
                prdata_reg <= rd_mux;
            end
            pready_reg <= 1'b1; // always ready, zero wait
            pslverr_reg <= psel && !penable && !addr_ok; // flagged for the access phase
        end
    end
    assign prdata = prdata_reg;
    assign pready = pready_reg;
    // the flop is high only in the cycle after setup, so no gating is needed
    assign pslverr = pslverr_reg;

    // writable configuration registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            conv_control_reg0 <= 7'h00;
            conv_control_reg1 <= 7'h00;
            conv_trigger_ctrl_reg <= 4'h0;
            high_limit_reg <= '0;
            low_limit_reg <= '0;
        end else begin
            if (wr_ctrl0) begin
                conv_control_reg0 <= {1'b0, pwdata[5:0]};
            end
            if (wr_ctrl1) begin
                conv_control_reg1 <= pwdata[6:0];
            end
            if (wr_trig) begin
                conv_trigger_ctrl_reg <= pwdata[3:0];
            end
            if (wr_hlim) begin
                high_limit_reg <= pwdata[DATA_BITS-1:0];
            end
            if (wr_llim) begin
                low_limit_reg <= pwdata[DATA_BITS-1:0];
            end
        end
    end

    // pwm trigger crosses in from outside: two flops before any use
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pwm_meta_reg <= 1'b0;
            pwm_sync_reg <= 1'b0;
            pwm_prev_reg <= 1'b0;
            start_prev_reg <= 1'b0;
        end else begin
            pwm_meta_reg <= pwm_trigger;
            pwm_sync_reg <= pwm_meta_reg;
            pwm_prev_reg <= pwm_sync_reg;
            start_prev_reg <= start_bit;
        end
    end

    // start on the falling edge of the start pulse, so low-high-low is one start
    logic sw_start, pwm_start, start_req, powered;
    assign powered = conv_control_reg0[adc_seq_pkg::PWR_BIT];
    assign sw_start = !trigger_source_sel && start_prev_reg && !start_bit;
    assign pwm_start = trigger_source_sel && pwm_sync_reg && !pwm_prev_reg;
    // a start while busy or unpowered is ignored
    assign start_req = powered && (state_reg == ST_IDLE) && (sw_start || pwm_start);

    // converter clock enable; runs only during a conversion
    logic conv_tick, running;
    assign running = (state_reg != ST_IDLE);
    conv_clk_div #(
        .WIDTH(7)
    ) u_div (
        .pclk(pclk),
        .presetn(presetn),
        .run(running),
        .sel(conv_clock_div_sel),
        .tick(conv_tick)
    );

    // sequence: counts converter periods, never system cycles
    logic conv_end;
    always_comb begin
        state_next = state_reg;
        phase_cnt_next = phase_cnt_reg;
        conv_end = 1'b0;
        case (state_reg)
            ST_IDLE: begin
                if (start_req) begin
                    state_next = ST_SAMPLE;
                    phase_cnt_next = 4'(adc_seq_pkg::SAMPLE_CYCLES - 1);
                end
            end
            ST_SAMPLE: begin
                if (!powered) begin
                    state_next = ST_IDLE; // power loss aborts
                end else if (conv_tick) begin
                    if (phase_cnt_reg == 4'h0) begin
                        state_next = ST_CONVERT;
                        phase_cnt_next = 4'(adc_seq_pkg::CONVERT_CYCLES - 1);
                    end else begin
                        phase_cnt_next = phase_cnt_reg - 4'h1;
                    end
                end
            end
            ST_CONVERT: begin
                if (!powered) begin
                    state_next = ST_IDLE;
                end else if (conv_tick) begin
                    if (phase_cnt_reg == 4'h0) begin
                        state_next = ST_IDLE;
                        conv_end = 1'b1;
                    end else begin
                        phase_cnt_next = phase_cnt_reg - 4'h1;
                    end
                end
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= ST_IDLE;
            phase_cnt_reg <= 4'h0;
        end else begin
            state_reg <= state_next;
            phase_cnt_reg <= phase_cnt_next;
        end
    end
    assign conv_busy_flag = running;

    // boundary checks against the fresh sample
    logic over_high, under_low, cmp_hit;
    assign over_high = high_limit_cmp_enable && (conv_data > high_limit_reg);
    assign under_low = low_limit_cmp_enable && (conv_data < low_limit_reg);
    assign cmp_hit = conv_end && (over_high || under_low);

    // result capture and request flags; a set beats a same-cycle clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            result_reg <= '0;
            done_flag_reg <= 1'b0;
            cmp_flag_reg <= 1'b0;
        end else begin
            if (conv_end) begin
                result_reg <= conv_data;
            end
            done_flag_reg <= conv_end ||
                (done_flag_reg && !(wr_stat && pwdata[adc_seq_pkg::DONE_BIT]));
            cmp_flag_reg <= cmp_hit ||
                (cmp_flag_reg && !(wr_stat && pwdata[adc_seq_pkg::CMP_BIT]));
        end
    end

    // analog side outputs, all registered
    logic [15:0] switch_next;
    input_mux_sel u_mux (
        .src(internal_source_sel),
        .ch(ext_channel_sel),
        .sel(switch_next)
    );
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            power_reg <= 1'b0;
            switch_reg <= 16'h0000;
            sample_reg <= 1'b0;
            convert_reg <= 1'b0;
            pin_dis_reg <= 14'h0000;
        end else begin
            power_reg <= powered;
            switch_reg <= powered ? switch_next : 16'h0000;
            sample_reg <= (state_next == ST_SAMPLE);
            convert_reg <= (state_next == ST_CONVERT);
            pin_dis_reg <= pin_function_sel_reg;
        end
    end
    assign input_switch = switch_reg;
    assign sample_strobe = sample_reg;
    assign convert_strobe = convert_reg;
    assign pin_digital_disable = pin_dis_reg;
    assign conv_done_irq = done_flag_reg;
    assign compare_irq = cmp_flag_reg;

    // checks
    a_busy_start: assert property (@(posedge pclk) disable iff (!presetn)
        start_req |=> conv_busy_flag) else $error("busy not set after start");
    a_done_end: assert property (@(posedge pclk) disable iff (!presetn)
        conv_end |=> done_flag_reg && !conv_busy_flag) else $error("end not flagged");
    a_power_off: assert property (@(posedge pclk) disable iff (!presetn)
        !powered |=> !conv_power_enable) else $error("power stays on");
    a_amp_route: assert property (@(posedge pclk) disable iff (!presetn)
        powered && internal_source_sel == adc_seq_pkg::SRC_AMP |=> input_switch == 16'h4000)
        else $error("amp route wrong");
    a_gnd_route: assert property (@(posedge pclk) disable iff (!presetn)
        powered && internal_source_sel[2:1] == 2'b01 |=> input_switch == 16'h8000)
        else $error("ground route wrong");
    a_float_route: assert property (@(posedge pclk) disable iff (!presetn)
        ext_channel_sel >= adc_seq_pkg::CH_FLOAT_A && internal_source_sel == 3'h0
        |=> input_switch == 16'h0000) else $error("floating code routed");
    a_sample_len: assert property (@(posedge pclk) disable iff (!presetn)
        conv_clock_div_sel == 3'h0 && powered && start_req |=> sample_strobe [*4] ##1 convert_strobe)
        else $error("sample phase length wrong");
    a_left_align: assert property (@(posedge pclk) disable iff (!presetn)
        !result_align_sel |-> result_aligned[3:0] == 4'h0) else $error("left align low bits");
    a_cmp_high: assert property (@(posedge pclk) disable iff (!presetn)
        conv_end && over_high |=> compare_irq) else $error("high bound missed");
    c_sw_conv: cover property (@(posedge pclk) sw_start && start_req);
    c_pwm_conv: cover property (@(posedge pclk) pwm_start && start_req);
    c_cmp: cover property (@(posedge pclk) cmp_hit);
endmodule
`default_nettype wire

// ==== verification/analog_front_model.sv ====
// Purpose: analog side of the converter: input lines, amplifier, ground
// Assumes: input_switch is one-hot and held for the whole conversion
// Notes: a floating or unpowered input gives a code that moves every cycle
`timescale 1ns/100ps
`default_nettype none
module analog_front_model (
    input wire logic pclk,
    input wire logic conv_power_enable,
    input wire logic [15:0] input_switch,
    output logic [11:0] conv_data
);
    logic [11:0] drift_reg = 12'h5C3; // stands in for an undriven node
    // free running pattern, so a float never reads as a steady level
    always_ff @(posedge pclk) begin
        drift_reg <= drift_reg + 12'h3A7;
    end
    // each line gives 12'hA50 plus its line number; ground reads zero
    always_comb begin
        conv_data = drift_reg;
        for (int k = 0; k < 15; k++) begin
            if (conv_power_enable && input_switch[k]) conv_data = 12'hA50 | 12'(k);
        end
        if (conv_power_enable && input_switch[15]) conv_data = 12'h000;
    end
endmodule
`default_nettype wire

// ==== verification/adc_sequencer_control_tb_top.sv ====
// Purpose: self-checking bench for the converter sequencer control block
// Assumes: apb slave with the package register map
// Notes: divider 7 keeps the converter period at 512 ns at 250 MHz
`timescale 1ns/100ps
`default_nettype none
module adc_sequencer_control_tb_top;
    logic pclk, presetn, psel, penable, pwrite, pwm_trigger, pready, pslverr, err;
    logic conv_power_enable, sample_strobe, convert_strobe, conv_done_irq, compare_irq;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [11:0] conv_data;
    logic [13:0] pin_function_sel_reg, pin_digital_disable;
    logic [15:0] input_switch;
    int fail_count, cmp_count, n_smp, n_cnv;
    // 250 MHz system clock
    initial begin
        pclk = 1'h0;
        forever #2 pclk = ~pclk;
    end
    adc_sequencer_control i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .pwm_trigger(pwm_trigger),
        .conv_data(conv_data), .pin_function_sel_reg(pin_function_sel_reg),
        .conv_power_enable(conv_power_enable), .input_switch(input_switch),
        .sample_strobe(sample_strobe), .convert_strobe(convert_strobe),
        .pin_digital_disable(pin_digital_disable), .conv_done_irq(conv_done_irq),
        .compare_irq(compare_irq));
    analog_front_model i_front (.pclk(pclk), .conv_power_enable(conv_power_enable),
        .input_switch(input_switch), .conv_data(conv_data));
    // verdict and end of run
    task automatic end_of_test();
        if (fail_count == 0 && cmp_count > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    // one apb transfer; request held until pready is sampled high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int i;
        @(posedge pclk);
        psel <= 1'h1;
        penable <= 1'h0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        for (i = 0; i < 20; i++) begin
            @(posedge pclk);
            if (pready === 1'h1) break;
        end
        if (i == 20) begin
            fail_count++;
            end_of_test();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask
    // counts strobe cycles until the done flag rises, bounded
    task automatic wait_done();
        int i;
        n_smp = 0;
        n_cnv = 0;
        for (i = 0; i < 5000 && conv_done_irq !== 1'h1; i++) begin
            @(posedge pclk);
            n_smp += int'(sample_strobe === 1'h1);
            n_cnv += int'(convert_strobe === 1'h1);
        end
        if (i == 5000) begin
            fail_count++;
            end_of_test();
        end
    endtask
    // software start: start bit low, high, low, then timing of both phases
    task automatic convert(input logic [3:0] ch, input int dv);
        apb(1'h1, adc_seq_pkg::OFF_STATUS, 32'h3);
        apb(1'h1, adc_seq_pkg::OFF_CTRL0, 32'h30 | 32'(ch));
        apb(1'h1, adc_seq_pkg::OFF_CTRL0, 32'h20 | 32'(ch));
        wait_done();
        check(n_smp, 32'(4 << dv));
        check(n_cnv, 32'(12 << dv));
    endtask
    function automatic logic [15:0] mux_exp(input int s, input int c);
        if (s == 1) return 16'h4000;
        if (s == 2 || s == 3) return 16'h8000;
        if (c <= 7 || c == 9 || c == 12 || c == 13) return 16'(1 << c);
        return 16'h0000;
    endfunction
    // limit cases: trigger word, high limit, low limit, expected compare flag
    logic [31:0] lim_tab [3][4] = '{'{32'hA, 32'hA52, 32'h0, 32'h1},
        '{32'h6, 32'hFFF, 32'hA54, 32'h1}, '{32'hE, 32'hA53, 32'hA53, 32'h0}};
    initial begin
        presetn = 1'h0;
        {psel, penable, pwrite, pwm_trigger} = 4'h0;
        paddr = 8'h00;
        pwdata = 32'h0;
        pin_function_sel_reg = 14'h2A5B;
        fail_count = 0;
        cmp_count = 0;
        repeat (2) @(posedge pclk);
        presetn <= 1'h1;
        repeat (2) @(posedge pclk);
        check(conv_power_enable, 32'h0);
        check(pin_digital_disable, 32'h2A5B);
        // divider first, then power, then source, trigger and format
        apb(1'h1, adc_seq_pkg::OFF_CTRL1, 32'h7);
        apb(1'h1, adc_seq_pkg::OFF_CTRL0, 32'h20);
        repeat (2) @(posedge pclk);
        check(conv_power_enable, 32'h1);
        repeat (20) @(posedge pclk); // settling after power on
        for (int s = 0; s < 8; s++) begin
            apb(1'h1, adc_seq_pkg::OFF_CTRL1, 32'(s << 4) | 32'h7);
            for (int c = 0; c < 16; c++) begin
                apb(1'h1, adc_seq_pkg::OFF_CTRL0, 32'h20 | 32'(c));
                repeat (2) @(posedge pclk);
                check(input_switch, mux_exp(s, c));
            end
        end
        apb(1'h1, adc_seq_pkg::OFF_CTRL1, 32'h7);
        apb(1'h1, adc_seq_pkg::OFF_TRIG, 32'h0);
        convert(4'h3, 7);
        apb(1'h0, adc_seq_pkg::OFF_RESULT, 32'h0);
        check(rd, 32'hA530);
        apb(1'h0, adc_seq_pkg::OFF_CTRL0, 32'h0);
        check(rd[6], 32'h0);
        check(conv_done_irq, 32'h1);
        apb(1'h1, adc_seq_pkg::OFF_CTRL1, 32'h1);
        for (int t = 0; t < 3; t++) begin
            apb(1'h1, adc_seq_pkg::OFF_TRIG, lim_tab[t][0]);
            apb(1'h1, adc_seq_pkg::OFF_HLIM, lim_tab[t][1]);
            apb(1'h1, adc_seq_pkg::OFF_LLIM, lim_tab[t][2]);
            convert(4'h3, 1);
            check(compare_irq, lim_tab[t][3]);
            apb(1'h0, adc_seq_pkg::OFF_RESULT, 32'h0);
            check(rd, 32'h0A53);
        end
        // amplifier source overrides the channel field
        apb(1'h1, adc_seq_pkg::OFF_CTRL1, 32'h11);
        convert(4'h3, 1);
        apb(1'h0, adc_seq_pkg::OFF_RESULT, 32'h0);
        check(rd, 32'h0A5E);
        // undivided converter clock: sixteen system cycles per conversion
        apb(1'h1, adc_seq_pkg::OFF_CTRL1, 32'h10);
        convert(4'h3, 0);
        apb(1'h0, adc_seq_pkg::OFF_RESULT, 32'h0);
        check(rd, 32'h0A5E);
        // pwm path: busy while running, clear at the end
        apb(1'h1, adc_seq_pkg::OFF_STATUS, 32'h3);
        apb(1'h1, adc_seq_pkg::OFF_TRIG, 32'h3);
        pwm_trigger <= 1'h1;
        for (int i = 0; i < 50 && sample_strobe !== 1'h1; i++) @(posedge pclk);
        // trigger never started the sequence: count it and stop
        if (sample_strobe !== 1'h1) begin
            fail_count++;
            end_of_test();
        end
        apb(1'h0, adc_seq_pkg::OFF_CTRL0, 32'h0);
        check(rd[6], 32'h1);
        wait_done();
        apb(1'h0, adc_seq_pkg::OFF_CTRL0, 32'h0);
        check(rd[6], 32'h0);
        apb(1'h0, 8'h1C, 32'h0);
        check(err, 32'h1);
        // converter idle, so power is dropped
        apb(1'h1, adc_seq_pkg::OFF_CTRL0, 32'h0);
        repeat (2) @(posedge pclk);
        check(conv_power_enable, 32'h0);
        end_of_test();
    end
endmodule
`default_nettype wire
